// File: hw/sacif_pkg.sv
/*
  constants for the converter conversion-control and read-out block:
  apb register map, control field positions, reset values, cycle counts.
  assumes a single 25 mhz core clock; every figure in ns becomes cycles here.
*/
//
// Overview of operation
// - wideband fast timings equal ordinary fast timings
// - conversion and busy within 360/485 ns
// - acquisition phase at least 140/182 ns
// - after reset pulse, busy high about 500 ns
// - parallel result valid 360/485 ns after start
// - parallel result valid before busy falls
// - bus driven on access request, released after
// - read-during-convert frame marker 15/135 ns after start
// - first shift edge after frame marker asserted
// - frame marker held past last shift edge
// - divider setting selects master shift-clock period in read-after-convert only
// - read-after-convert busy bounded per divider setting
// - read-after-convert marker 375/500 ns, busy drops after
// - slave shift clock; output updated per active edge
// - serial outputs driven only while chip select low
// - fast select high: normal select picks wideband
// - both selects low: normal mode
// - every result is one 16-bit word
package sacif_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] RSLT_OFS = 12'h008;

  // ctrl fields
  localparam int CTRL_FAST_BIT = 0;
  localparam int CTRL_NORMSEL_BIT = 1;
  localparam int CTRL_SERIAL_BIT = 2;
  localparam int CTRL_MASTER_BIT = 3;
  localparam int CTRL_RAC_BIT = 4;
  localparam int CTRL_DIV_LSB = 5;
  localparam int CTRL_WIDTH = 7;
  localparam logic [6:0] CTRL_RESET = 7'h00;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RSTBUSY_BIT = 1;
  localparam int STAT_FAST_BIT = 2;
  localparam int STAT_WIDE_BIT = 3;
  localparam int STAT_XFER_BIT = 4;

  localparam int RESULT_W = 16;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // -------------------------------------------------------------
  // timing, ns and derived cycles
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_CONV_FAST_NS = 360;
  localparam int T_CONV_NORM_NS = 485;
  localparam int T_ACQ_FAST_NS = 140;
  localparam int T_ACQ_NORM_NS = 182;
  localparam int T_RST_BUSY_NS = 500;
  localparam int T_SYNC_RDC_FAST_NS = 15;
  localparam int T_SYNC_RDC_NORM_NS = 135;
  localparam int T_SYNC_RAC_FAST_NS = 375;
  localparam int T_SYNC_RAC_NORM_NS = 500;

  // longest times round down, least times round up, never below one
  localparam int CONV_FAST_CYC = T_CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int CONV_NORM_CYC = T_CONV_NORM_NS / CLK_PERIOD_NS;
  localparam int ACQ_FAST_CYC = (T_ACQ_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_NORM_CYC = (T_ACQ_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_BUSY_CYC = T_RST_BUSY_NS / CLK_PERIOD_NS;
  localparam int SYNC_RDC_FAST_CYC = (T_SYNC_RDC_FAST_NS / CLK_PERIOD_NS < 1) ? 1 :
                                     T_SYNC_RDC_FAST_NS / CLK_PERIOD_NS;
  localparam int SYNC_RDC_NORM_CYC = T_SYNC_RDC_NORM_NS / CLK_PERIOD_NS;
  localparam int SYNC_RAC_FAST_CYC = T_SYNC_RAC_FAST_NS / CLK_PERIOD_NS;
  localparam int SYNC_RAC_NORM_CYC = T_SYNC_RAC_NORM_NS / CLK_PERIOD_NS;

  localparam int CNT_W = 12;

  typedef enum logic [2:0] {
    SACIF_IDLE,
    SACIF_CONV,
    SACIF_XFER,
    SACIF_ACQ,
    SACIF_RST_HOLD,
    SACIF_RST_BUSY
  } sacif_state_t;

endpackage : sacif_pkg

// File: hw/sacif_top.sv
/*
  conversion control and result read-out: start/busy sequencing, reset
  busy window, tri-state parallel bus, master and slave serial link,
  apb register slave.
  assumes the sar core presents its code on core_code_i during conversion;
  all pins are asynchronous and pass a three-stage synchroniser.
*/
`timescale 1ns/10ps
module sacif_top (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // conversion control pins
  input wire logic convert_start_n_i,
  input wire logic reset_pulse_i,
  output logic busy_o,
  // sar core result
  input wire logic [15:0] core_code_i,
  // parallel bus
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  output logic [15:0] data_o,
  output logic data_oe_o,
  // serial link
  input wire logic ext_shift_clk_i,
  input wire logic chain_serial_in_i,
  output logic serial_result_out_o,
  output logic serial_result_out_oe_o,
  output logic frame_o,
  output logic frame_oe_o,
  output logic shift_clk_o,
  output logic shift_clk_oe_o
);

  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  localparam int NPIN = 6;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;
  logic [NPIN-1:0] pin_s3_q;
  logic [NPIN-1:0] pin_q;
  logic start_n_q;
  logic rstp_q;
  logic csn_q;
  logic rdn_q;
  logic eclk_q;
  logic chain_q;
  logic start_prev_q;
  logic rstp_prev_q;
  logic eclk_prev_q;

  assign pin_raw = {chain_serial_in_i, ext_shift_clk_i, rd_n_i, cs_n_i, reset_pulse_i,
                    convert_start_n_i};

  // idle-high pins reset high so no false edge appears at release
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      localparam logic RV = (gi == 1 || gi == 4 || gi == 5) ? 1'b0 : 1'b1;
      always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pin_s1_q[gi] <= RV;
          pin_s2_q[gi] <= RV;
          pin_s3_q[gi] <= RV;
          pin_q[gi] <= RV;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  assign start_n_q = pin_q[0];
  assign rstp_q = pin_q[1];
  assign csn_q = pin_q[2];
  assign rdn_q = pin_q[3];
  assign eclk_q = pin_q[4];
  assign chain_q = pin_q[5];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_prev_q <= 1'b1;
      rstp_prev_q <= 1'b0;
      eclk_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_n_q;
      rstp_prev_q <= rstp_q;
      eclk_prev_q <= eclk_q;
    end
  end

  logic start_fall;
  logic rstp_end;
  logic eclk_rise;
  assign start_fall = start_prev_q & ~start_n_q;
  assign rstp_end = rstp_prev_q & ~rstp_q;
  assign eclk_rise = ~eclk_prev_q & eclk_q;

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  logic [6:0] ctrl_q;
  logic [15:0] result_q;
  logic busy_q;
  logic xfer_act_q;
  logic fast_q;
  logic wide_q;
  logic rac_q;
  sacif_pkg::sacif_state_t state_q;

  function automatic logic is_fast(input logic [6:0] c);
    is_fast = c[sacif_pkg::CTRL_FAST_BIT];
  endfunction : is_fast

  logic apb_wr;
  logic apb_setup;
  logic hit;
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_setup = psel_i & ~penable_i;
  assign hit = (paddr_i == sacif_pkg::CTRL_OFS) | (paddr_i == sacif_pkg::STAT_OFS) |
               (paddr_i == sacif_pkg::RSLT_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= sacif_pkg::CTRL_RESET;
    end else if (apb_wr && pstrb_i[0] && paddr_i == sacif_pkg::CTRL_OFS) begin
      ctrl_q <= pwdata_i[sacif_pkg::CTRL_WIDTH-1:0];
    end
  end

  // read data captured in setup, stable through the access phase
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup && !pwrite_i) begin
      prdata_o <= 32'h0000_0000;
      case (paddr_i)
        sacif_pkg::CTRL_OFS: prdata_o[sacif_pkg::CTRL_WIDTH-1:0] <= ctrl_q;
        sacif_pkg::STAT_OFS: begin
          prdata_o[sacif_pkg::STAT_BUSY_BIT] <= busy_q;
          prdata_o[sacif_pkg::STAT_RSTBUSY_BIT] <= (state_q == sacif_pkg::SACIF_RST_BUSY);
          prdata_o[sacif_pkg::STAT_FAST_BIT] <= fast_q;
          prdata_o[sacif_pkg::STAT_WIDE_BIT] <= wide_q;
          prdata_o[sacif_pkg::STAT_XFER_BIT] <= xfer_act_q;
        end
        sacif_pkg::RSLT_OFS: prdata_o[15:0] <= result_q;
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // -------------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------------
  logic [sacif_pkg::CNT_W-1:0] cnt_q;
  logic [sacif_pkg::CNT_W-1:0] elapsed_q;
  logic [sacif_pkg::CNT_W-1:0] conv_len;
  logic [sacif_pkg::CNT_W-1:0] acq_len;
  logic [sacif_pkg::CNT_W-1:0] sync_at;
  logic serial_m;
  logic sync_q;
  logic frame_done;

  // wideband shares every count with ordinary fast mode
  assign conv_len = fast_q ? sacif_pkg::CNT_W'(sacif_pkg::CONV_FAST_CYC) :
                             sacif_pkg::CNT_W'(sacif_pkg::CONV_NORM_CYC);
  assign acq_len = fast_q ? sacif_pkg::CNT_W'(sacif_pkg::ACQ_FAST_CYC) :
                            sacif_pkg::CNT_W'(sacif_pkg::ACQ_NORM_CYC);
  assign sync_at = rac_q ?
    (fast_q ? sacif_pkg::CNT_W'(sacif_pkg::SYNC_RAC_FAST_CYC) :
              sacif_pkg::CNT_W'(sacif_pkg::SYNC_RAC_NORM_CYC)) :
    (fast_q ? sacif_pkg::CNT_W'(sacif_pkg::SYNC_RDC_FAST_CYC) :
              sacif_pkg::CNT_W'(sacif_pkg::SYNC_RDC_NORM_CYC));
  assign serial_m = ctrl_q[sacif_pkg::CTRL_SERIAL_BIT] & ctrl_q[sacif_pkg::CTRL_MASTER_BIT];

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= sacif_pkg::SACIF_IDLE;
      cnt_q <= '0;
      elapsed_q <= '0;
      busy_q <= 1'b0;
      fast_q <= 1'b0;
      wide_q <= 1'b0;
      rac_q <= 1'b0;
      result_q <= sacif_pkg::RESULT_RESET;
    end else if (rstp_q) begin
      state_q <= sacif_pkg::SACIF_RST_HOLD;
      busy_q <= 1'b0;
    end else begin
      elapsed_q <= elapsed_q + 1'b1;
      case (state_q)
        sacif_pkg::SACIF_IDLE: begin
          // starts during busy or acquisition are ignored
          if (start_fall) begin
            state_q <= sacif_pkg::SACIF_CONV;
            busy_q <= 1'b1;
            fast_q <= is_fast(ctrl_q);
            wide_q <= is_fast(ctrl_q) & ctrl_q[sacif_pkg::CTRL_NORMSEL_BIT];
            rac_q <= serial_m & ctrl_q[sacif_pkg::CTRL_RAC_BIT];
            elapsed_q <= '0;
            cnt_q <= '0;
          end
        end
        sacif_pkg::SACIF_CONV: begin
          cnt_q <= cnt_q + 1'b1;
          // latch two cycles ahead: data_o lags result_q by one register
          if (cnt_q == conv_len - 2'd3) begin
            result_q <= core_code_i;
          end
          if (cnt_q == conv_len - 1'b1) begin
            cnt_q <= '0;
            if (rac_q) begin
              state_q <= sacif_pkg::SACIF_XFER;
            end else begin
              busy_q <= 1'b0;
              state_q <= sacif_pkg::SACIF_ACQ;
            end
          end
        end
        sacif_pkg::SACIF_XFER: begin
          // busy follows the frame marker down one cycle later
          if (!xfer_act_q && !sync_q && elapsed_q > sync_at) begin
            busy_q <= 1'b0;
            state_q <= sacif_pkg::SACIF_ACQ;
          end
        end
        sacif_pkg::SACIF_ACQ: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == acq_len - 1'b1) begin
            state_q <= sacif_pkg::SACIF_IDLE;
          end
        end
        sacif_pkg::SACIF_RST_HOLD: begin
          if (rstp_end) begin
            busy_q <= 1'b1;
            cnt_q <= '0;
            state_q <= sacif_pkg::SACIF_RST_BUSY;
          end
        end
        sacif_pkg::SACIF_RST_BUSY: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == sacif_pkg::CNT_W'(sacif_pkg::RST_BUSY_CYC - 1)) begin
            busy_q <= 1'b0;
            state_q <= sacif_pkg::SACIF_IDLE;
          end
        end
        default: state_q <= sacif_pkg::SACIF_IDLE;
      endcase
    end
  end

  assign busy_o = busy_q;

  // -------------------------------------------------------------
  // master serial: divider, frame marker, shift clock
  // -------------------------------------------------------------
  logic [15:0] mshift_q;
  logic [4:0] bits_q;
  logic mclk_q;
  logic [3:0] div_q;
  logic tick;
  logic [3:0] div_len;
  logic frame_go;

  // read-during-convert runs the fastest setting regardless of divider
  assign div_len = rac_q ? 4'((4'h1 << ctrl_q[sacif_pkg::CTRL_DIV_LSB+:2]) - 4'h1) :
                           4'h0;
  assign tick = xfer_act_q & (div_q == 4'h0);
  assign frame_go = serial_m & (state_q == sacif_pkg::SACIF_CONV || state_q ==
                    sacif_pkg::SACIF_XFER) & ~xfer_act_q & ~sync_q & (elapsed_q == sync_at);
  assign frame_done = tick & (bits_q == 5'h00) & ~mclk_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mshift_q <= sacif_pkg::RESULT_RESET;
      bits_q <= 5'h00;
      mclk_q <= 1'b0;
      sync_q <= 1'b0;
      xfer_act_q <= 1'b0;
      div_q <= 4'h0;
    end else if (rstp_q) begin
      sync_q <= 1'b0;
      mclk_q <= 1'b0;
      xfer_act_q <= 1'b0;
    end else if (frame_go) begin
      // new word in read-after-convert, previous word otherwise
      mshift_q <= result_q;
      bits_q <= 5'h10;
      sync_q <= 1'b1;
      xfer_act_q <= 1'b1;
      div_q <= div_len;
    end else if (xfer_act_q) begin
      div_q <= (div_q == 4'h0) ? div_len : div_q - 4'h1;
      if (tick) begin
        if (frame_done) begin
          sync_q <= 1'b0;
          xfer_act_q <= 1'b0;
        end else if (!mclk_q) begin
          mclk_q <= 1'b1;
        end else begin
          mclk_q <= 1'b0;
          mshift_q <= {mshift_q[14:0], 1'b0};
          bits_q <= bits_q - 5'h01;
        end
      end
    end
  end

  // -------------------------------------------------------------
  // slave serial: external shift clock, daisy chain in
  // -------------------------------------------------------------
  logic [15:0] sshift_q;
  logic end_of_conv;
  assign end_of_conv = (state_q == sacif_pkg::SACIF_CONV) && (cnt_q == conv_len - 1'b1);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sshift_q <= sacif_pkg::RESULT_RESET;
    end else if (end_of_conv) begin
      sshift_q <= result_q;
    end else if (eclk_rise && !csn_q) begin
      sshift_q <= {sshift_q[14:0], chain_q};
    end
  end

  // -------------------------------------------------------------
  // pin outputs
  // -------------------------------------------------------------
  logic ser_on;
  logic [15:0] data_q;
  logic data_oe_q;
  logic sout_q;
  assign ser_on = ctrl_q[sacif_pkg::CTRL_SERIAL_BIT] & ~csn_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= 16'h0000;
      data_oe_q <= 1'b0;
      sout_q <= 1'b0;
    end else begin
      data_q <= result_q;
      data_oe_q <= ~ctrl_q[sacif_pkg::CTRL_SERIAL_BIT] & ~csn_q & ~rdn_q;
      sout_q <= serial_m ? mshift_q[15] : sshift_q[15];
    end
  end

  assign data_o = data_q;
  assign data_oe_o = data_oe_q;
  assign serial_result_out_o = sout_q;
  assign serial_result_out_oe_o = ser_on;
  assign frame_o = sync_q;
  assign frame_oe_o = ser_on & ctrl_q[sacif_pkg::CTRL_MASTER_BIT];
  assign shift_clk_o = mclk_q;
  assign shift_clk_oe_o = ser_on & ctrl_q[sacif_pkg::CTRL_MASTER_BIT];

endmodule : sacif_top

// File: bench/sacif_assertions.sv
/*
  checker for sacif_top: busy, frame, shift clock and bus enables at the pins.
  assumes it is bound to sacif_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module sacif_chk (
  // clock, reset and apb
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  // pins
  input wire logic reset_pulse_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic busy_o,
  input wire logic [15:0] data_o,
  input wire logic data_oe_o,
  input wire logic frame_o,
  input wire logic frame_oe_o,
  input wire logic shift_clk_o,
  input wire logic shift_clk_oe_o,
  input wire logic serial_result_out_oe_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [6:0] ctrl_q;
  logic [8:0] busy_cnt_q;
  logic [4:0] bit_cnt_q;
  logic frame_q;
  logic sck_q;
  logic rac_w;
  assign rac_w = ctrl_q[2] & ctrl_q[3] & ctrl_q[4];
  // mode known only from the apb writes, so shadow the control word
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q <= sacif_pkg::CTRL_RESET;
    end else if (psel_i && penable_i && pwrite_i && pstrb_i[0] &&
                 paddr_i == sacif_pkg::CTRL_OFS) begin
      ctrl_q <= pwdata_i[6:0];
    end
  end
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_cnt_q <= 9'h000;
      bit_cnt_q <= 5'h00;
      frame_q <= 1'b0;
      sck_q <= 1'b0;
    end else begin
      busy_cnt_q <= busy_o ? busy_cnt_q + 9'h001 : 9'h000;
      frame_q <= frame_o;
      sck_q <= shift_clk_o;
      if (frame_o && !frame_q) begin
        bit_cnt_q <= 5'h00;
      end else if (shift_clk_o && !sck_q) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_busy_len;
    busy_o && !rac_w |-> busy_cnt_q < 9'h00C;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy high too long");
  property p_acq;
    $fell(busy_o) |-> !busy_o [*5];
  endproperty
  a_acq: assert property (p_acq) else $error("acquisition cut short");
  property p_rst_win;
    $fell(reset_pulse_i) |-> ##[2:7] $rose(busy_o) ##1 busy_o [*8];
  endproperty
  a_rst_win: assert property (p_rst_win) else $error("reset busy window wrong");
  property p_ser_hiz;
    cs_n_i [*5] |-> !(frame_oe_o || shift_clk_oe_o || serial_result_out_oe_o);
  endproperty
  a_ser_hiz: assert property (p_ser_hiz) else $error("serial pins driven");
  property p_par_on;
    (!cs_n_i && !rd_n_i && !ctrl_q[2]) [*6] |-> data_oe_o;
  endproperty
  a_par_on: assert property (p_par_on) else $error("bus not driven");
  property p_par_valid;
    $fell(busy_o) && !ctrl_q[2] |-> $stable(data_o) ##1 $stable(data_o);
  endproperty
  a_par_valid: assert property (p_par_valid) else $error("data late");
  property p_first_edge;
    $rose(shift_clk_o) |-> $past(frame_o);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("edge before frame");
  property p_rdc_sync;
    $rose(busy_o) && ctrl_q[3:2] == 2'h3 && !ctrl_q[4] |-> ##[1:4] frame_o;
  endproperty
  a_rdc_sync: assert property (p_rdc_sync) else $error("frame marker late");
  property p_word;
    $fell(frame_o) |-> bit_cnt_q == 5'h10;
  endproperty
  a_word: assert property (p_word) else $error("frame not 16 bits");
endmodule : sacif_chk

// File: bench/sacif_host_mdl.sv
/*
  host model on the pins: start and reset pulses, parallel and slave reads,
  capture of the master serial word and its shift-clock period.
  assumes one core clock; pins change just after a rising edge.
*/
`timescale 1ns/10ps
module sacif_host_mdl (
  // from the device
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic [15:0] bus_i,
  input wire logic sdo_i,
  input wire logic sck_i,
  // to the device
  output logic start_n_o,
  output logic rst_pulse_o,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic ext_sck_o,
  output logic chain_o
);
  logic [7:0] gap_q = 8'h00;
  logic [7:0] idle_q = 8'h00;
  logic [7:0] pcnt_q = 8'h00;
  logic sck_q = 1'b0;
  logic sd_q = 1'b0;
  logic [31:0] per = 32'h0;
  logic [15:0] mword = 16'h0000;
  initial begin
    start_n_o = 1'b1;
    rst_pulse_o = 1'b0;
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    ext_sck_o = 1'b0;
    chain_o = 1'b0;
  end
  // master word taken at each falling shift edge, period rise to rise
  always @(posedge clk_i) begin
    gap_q <= start_n_o ? gap_q + {7'h00, gap_q != 8'hFF} : 8'h00;
    idle_q <= busy_i ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
    sck_q <= sck_i;
    sd_q <= sdo_i;
    pcnt_q <= (sck_i && !sck_q) ? 8'h01 : pcnt_q + 8'h01;
    if (sck_i && !sck_q) begin
      per <= {24'h0, pcnt_q};
    end
    if (sck_q && !sck_i) begin
      mword <= {mword[14:0], sd_q};
    end
  end
  task automatic measure(output logic [31:0] bw);
    while (busy_i !== 1'b1) begin
      @(negedge clk_i);
    end
    bw = 32'h0;
    while (busy_i === 1'b1) begin
      @(negedge clk_i);
      bw++;
    end
  endtask : measure
  task automatic convert(output logic [31:0] bw);
    // idle margin also covers the acquisition window; run stays far below 1 ms
    while (busy_i !== 1'b0 || idle_q < 8'h08 || gap_q < 8'h11) begin
      @(negedge clk_i);
    end
    @(posedge clk_i);
    start_n_o <= 1'b0;
    // two cycles low: the pin filter drops one-cycle pulses
    repeat (2) @(posedge clk_i);
    start_n_o <= 1'b1;
    measure(bw);
  endtask : convert
  task automatic rst(output logic [31:0] bw);
    @(posedge clk_i);
    rst_pulse_o <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_pulse_o <= 1'b0;
    measure(bw);
  endtask : rst
  task automatic sel(input logic v);
    @(posedge clk_i);
    cs_n_o <= v;
  endtask : sel
  task automatic par_read(output logic [15:0] w);
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rd_n_o <= 1'b0;
    repeat (6) @(negedge clk_i);
    w = bus_i;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    repeat (6) @(negedge clk_i);
  endtask : par_read
  task automatic slave_read(output logic [15:0] w);
    sel(1'b0);
    repeat (6) @(negedge clk_i);
    for (int i = 0; i < 16; i++) begin
      w = {w[14:0], sdo_i};
      @(posedge clk_i);
      ext_sck_o <= 1'b1;
      chain_o <= ~chain_o;
      repeat (5) @(posedge clk_i);
      ext_sck_o <= 1'b0;
      repeat (5) @(negedge clk_i);
    end
    sel(1'b1);
  endtask : slave_read
endmodule : sacif_host_mdl

// File: bench/sacif_top_tb.sv
/*
  testbench for sacif_top: apb master, host model, table of conversions.
  assumes the checker is bound below and the host model owns the pins.
*/
`timescale 1ns/10ps
module sacif_top_tb;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [15:0] code;
    logic [3:0] bw;
  } sacif_tb_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [15:0] code = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, busy, data_oe, sdo, sdo_oe, frame, frame_oe, sck, sck_oe;
  logic start_n, rst_p, cs_n, rd_n, ext_sck, chain;
  logic [15:0] data;
  wire [15:0] pbus = data_oe ? data : 16'hZZZZ;
  int n_fail = 0;
  int check_count = 0;
  sacif_tb_row_t rows [8] = '{'{7'h01, 16'hA5C3, 4'h9}, '{7'h03, 16'h0001, 4'h9},
    '{7'h00, 16'hFFFE, 4'hC}, '{7'h02, 16'h8000, 4'hC}, '{7'h1D, 16'h1234, 4'h0},
    '{7'h3D, 16'hC0DE, 4'h0}, '{7'h5D, 16'h7F01, 4'h0}, '{7'h7D, 16'h00FF, 4'h0}};
  sacif_top i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .convert_start_n_i(start_n), .reset_pulse_i(rst_p), .busy_o(busy),
    .core_code_i(code), .cs_n_i(cs_n), .rd_n_i(rd_n), .data_o(data), .data_oe_o(data_oe),
    .ext_shift_clk_i(ext_sck), .chain_serial_in_i(chain), .serial_result_out_o(sdo),
    .serial_result_out_oe_o(sdo_oe), .frame_o(frame), .frame_oe_o(frame_oe),
    .shift_clk_o(sck), .shift_clk_oe_o(sck_oe));
  sacif_host_mdl i_host (.clk_i(clk), .busy_i(busy), .bus_i(pbus), .sdo_i(sdo),
    .sck_i(sck), .start_n_o(start_n), .rst_pulse_o(rst_p), .cs_n_o(cs_n), .rd_n_o(rd_n),
    .ext_sck_o(ext_sck), .chain_o(chain));
  initial begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      n_fail++;
      $display("BAD t=%0t got %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
  initial begin
    logic [31:0] r;
    logic [31:0] bw;
    logic e;
    logic [15:0] w;
    logic [6:0] c;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, sacif_pkg::CTRL_OFS, 32'h0, 4'hF, r, e);
    chk(r, {25'h0, sacif_pkg::CTRL_RESET});
    apb(1'b1, sacif_pkg::CTRL_OFS, 32'h7F, 4'h0, r, e);
    apb(1'b0, sacif_pkg::CTRL_OFS, 32'h0, 4'hF, r, e);
    chk(r, 32'h0);
    apb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF, r, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, sacif_pkg::RSLT_OFS, 32'h0, 4'hF, r, e);
    chk(r, {16'h0000, sacif_pkg::RESULT_RESET});
    foreach (rows[i]) begin
      c = rows[i].ctrl;
      apb(1'b1, sacif_pkg::CTRL_OFS, {25'h0, c}, 4'hF, r, e);
      code <= rows[i].code;
      i_host.sel(~c[2]);
      i_host.convert(bw);
      if (rows[i].bw != 4'h0) begin
        chk(bw, {28'h0, rows[i].bw});
      end
      apb(1'b0, sacif_pkg::RSLT_OFS, 32'h0, 4'hF, r, e);
      chk(r, {16'h0000, rows[i].code});
      apb(1'b0, sacif_pkg::STAT_OFS, 32'h0, 4'hF, r, e);
      chk(r, {28'h0, c[0] & c[1], c[0], 2'h0});
      if (!c[2]) begin
        i_host.par_read(w);
        chk({16'h0000, w}, {16'h0000, rows[i].code});
      end else begin
        chk({29'h0, sdo_oe, frame_oe, sck_oe}, 32'h7);
        i_host.sel(1'b1);
        chk(i_host.per, 32'h2 << c[6:5]);
        chk({16'h0000, i_host.mword}, {16'h0000, rows[i].code});
      end
    end
    apb(1'b1, sacif_pkg::CTRL_OFS, 32'h0D, 4'hF, r, e);
    i_host.sel(1'b0);
    code <= 16'h3C3C;
    i_host.convert(bw);
    chk(bw, 32'h9);
    i_host.sel(1'b1);
    apb(1'b1, sacif_pkg::CTRL_OFS, 32'h04, 4'hF, r, e);
    code <= 16'h5A3C;
    i_host.convert(bw);
    chk(bw, 32'hC);
    i_host.slave_read(w);
    chk({16'h0000, w}, 32'h5A3C);
    i_host.rst(bw);
    chk(bw, 32'hC);
    report_and_stop;
  end
endmodule : sacif_top_tb
bind sacif_top sacif_chk u_chk (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .reset_pulse_i(reset_pulse_i), .cs_n_i(cs_n_i),
  .rd_n_i(rd_n_i), .busy_o(busy_o), .data_o(data_o), .data_oe_o(data_oe_o),
  .frame_o(frame_o), .frame_oe_o(frame_oe_o), .shift_clk_o(shift_clk_o),
  .shift_clk_oe_o(shift_clk_oe_o), .serial_result_out_oe_o(serial_result_out_oe_o));
